//--- xbar_arb_pkg.sv
// package: constants, register map and carrier types for the slave port arbiter
package xbar_arb_pkg;

    localparam int NUM_MASTERS = 4;
    localparam int MID_W       = 2;

    // register offsets (word addresses on the plain register port)
    localparam logic [3:0] SLAVE_PRIORITY_OFS  = 4'h0;
    localparam logic [3:0] SLAVE_CONTROL_OFS   = 4'h1;
    localparam logic [3:0] MASTER_GENERAL_OFS  = 4'h2;
    localparam logic [3:0] STATUS_OFS          = 4'h3;

    // slave control field positions
    localparam int PARK_LSB  = 0;
    localparam int PARK_CTL_LSB = 4;
    localparam int ARB_BIT   = 8;
    // master general control: 3 bits per master
    localparam int UARB_W    = 3;

    // reset values
    localparam logic [31:0] SLAVE_PRIORITY_RST = 32'h0000_3210;
    localparam logic [31:0] SLAVE_CONTROL_RST  = 32'h0000_0000;
    localparam logic [31:0] MASTER_GENERAL_RST = 32'h0000_0000;

    // arbitration timing: a non-parked master pays this many switch cycles
    localparam int SWITCH_CYCLES = 1;

    typedef enum logic [1:0] {
        PARK_FIXED = 2'h0,
        PARK_LAST  = 2'h1,
        PARK_NONE  = 2'h2
    } park_mode_type;

    typedef enum logic [2:0] {
        UARB_NEVER = 3'h0,
        UARB_ANY   = 3'h1,
        UARB_FOUR  = 3'h2,
        UARB_EIGHT = 3'h3,
        UARB_SIXTN = 3'h4
    } undef_arb_type;

    // htrans codes
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_BUSY = 2'h1;
    localparam logic [1:0] HTRANS_NSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ  = 2'h3;
    localparam logic [2:0] HBURST_INCR = 3'h1;

    // per-master request carrier
    typedef struct packed {
        logic [1:0] htrans;
        logic [2:0] hburst;
    } master_req_type;

    // register port carrier
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

endpackage : xbar_arb_pkg

//--- burst_beat_counter.sv
// module: counts beats of an undefined-length burst and flags arbitration points
`timescale 1ns/1ps
module burst_beat_counter (
    input  wire logic                   mclk,
    input  wire logic                   rst_n,
    input  wire logic                   beatDone,
    input  wire logic                   burstStart,
    input  wire xbar_arb_pkg::undef_arb_type aulbSel,
    output logic                        arbPoint
);
    import xbar_arb_pkg::*;

    logic [4:0] beatCnt_ff;
    logic [4:0] nxt_beatCnt;
    logic [4:0] limit;
    logic [4:0] cntNow;

    // beat count limit from the undefined burst arbitration point setting
    always_comb begin
        case (aulbSel)
            UARB_FOUR:  limit = 5'h04;
            UARB_EIGHT: limit = 5'h08;
            UARB_SIXTN: limit = 5'h10;
            default:    limit = 5'h00;
        endcase
    end

    // counter restarts at a burst start (that beat counts as the first) and after each point
    always_comb begin
        cntNow      = burstStart ? 5'h00 : beatCnt_ff;
        nxt_beatCnt = beatCnt_ff;
        if (beatDone) begin
            nxt_beatCnt = (limit != 5'h00 && cntNow + 5'h01 >= limit) ? 5'h00
                          : cntNow + 5'h01;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            beatCnt_ff <= 5'h00;
        end else begin
            beatCnt_ff <= nxt_beatCnt;
        end
    end

    // arbitration point: any beat, or every 4/8/16 beats, never otherwise
    always_comb begin
        case (aulbSel)
            UARB_ANY:                        arbPoint = beatDone;
            UARB_FOUR, UARB_EIGHT, UARB_SIXTN:
                arbPoint = beatDone && (cntNow + 5'h01 >= limit);
            default:                         arbPoint = 1'b0;
        endcase
    end

endmodule : burst_beat_counter

//--- crossbar_slave_port_arbiter.sv
// module: arbitration and parking for one crossbar slave port
`timescale 1ns/1ps
module crossbar_slave_port_arbiter #(
    parameter int NM = xbar_arb_pkg::NUM_MASTERS
) (
    input  wire logic                          mclk,
    input  wire logic                          rst_n,
    input  wire xbar_arb_pkg::master_req_type  mReq [NM],
    input  wire logic                          hreadySlv,
    input  wire xbar_arb_pkg::reg_req_type     regReq,
    output logic [31:0]                        regRdata,
    output logic [xbar_arb_pkg::MID_W-1:0]     grantId,
    output logic                               grantValid,
    output logic [NM-1:0]                      stallMaster
);
    import xbar_arb_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_SWITCH = 3'b010,
        ST_BUSY   = 3'b100
    } arb_state_type;

    // registers
    logic [31:0]        prio_ff, ctrl_ff, mgen_ff, rdata_ff;
    logic [31:0]        nxt_prio, nxt_ctrl, nxt_mgen, nxt_rdata;
    arb_state_type      state_ff, nxt_state;
    logic [MID_W-1:0]   owner_ff, nxt_owner, last_ff, nxt_last;
    logic               attached_ff, nxt_attached;

    logic [NM-1:0]      reqVec;
    logic               anyReq;
    logic [MID_W-1:0]   winner;
    logic               ownerReq, ownerActive, boundary, undefArb;
    logic [1:0]         parkCtl;
    logic [MID_W-1:0]   parkSel, parkTarget;
    logic               roundRobin;

    assign parkSel    = ctrl_ff[PARK_LSB +: MID_W];
    assign parkCtl    = ctrl_ff[PARK_CTL_LSB +: 2];
    assign roundRobin = ctrl_ff[ARB_BIT];

    // request vector: a nonidle, nonbusy transfer start or continuation
    always_comb begin
        for (int i = 0; i < NM; i++) begin
            reqVec[i] = mReq[i].htrans[1];
        end
    end
    assign anyReq = |reqVec;

    // ranking: fixed priority or distance after last user
    always_comb begin
        logic [MID_W-1:0] bestLvl;
        logic [MID_W-1:0] lvl;
        logic [MID_W-1:0] idx;
        logic             found;
        bestLvl = '1;
        winner  = owner_ff;
        found   = 1'b0;
        lvl     = '0;
        idx     = '0;
        for (int i = 0; i < NM; i++) begin
            if (roundRobin) begin
                idx = MID_W'(last_ff + MID_W'(i) + 1'b1);
                if (reqVec[idx] && !found) begin
                    winner = idx;
                    found  = 1'b1;
                end
            end else begin
                lvl = prio_ff[i*4 +: MID_W];
                if (reqVec[i] && (!found || lvl < bestLvl)) begin
                    bestLvl = lvl;
                    winner  = MID_W'(i);
                    found   = 1'b1;
                end
            end
        end
    end

    // undefined-length burst arbitration points for the current owner
    burst_beat_counter u_beats (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .beatDone   (hreadySlv && ownerActive),
        .burstStart (hreadySlv && ownerActive && mReq[owner_ff].htrans == HTRANS_NSEQ),
        .aulbSel    (undef_arb_type'(mgen_ff[owner_ff*UARB_W +: UARB_W])),
        .arbPoint   (undefArb)
    );

    assign ownerReq    = attached_ff && reqVec[owner_ff];
    // a parked owner is served at idle only if it also wins against other requesters
    assign ownerActive = ownerReq && (state_ff != ST_IDLE || winner == owner_ff);
    // boundary: owner has finished its whole cycle, or an undefined burst arbitration point
    assign boundary = !ownerReq
                      || (hreadySlv && mReq[owner_ff].hburst == HBURST_INCR && undefArb);

    // park target chosen from the park control field
    always_comb begin
        case (parkCtl)
            PARK_LAST: parkTarget = last_ff;
            default:   parkTarget = parkSel;
        endcase
    end

    // arbitration state machine next values
    always_comb begin
        nxt_state    = state_ff;
        nxt_owner    = owner_ff;
        nxt_last     = last_ff;
        nxt_attached = attached_ff;
        case (state_ff)
            ST_IDLE: begin
                if (ownerActive) begin
                    nxt_state = ST_BUSY;
                end else if (anyReq) begin
                    // the request cycle itself is the single switch cycle
                    nxt_owner    = winner;
                    nxt_attached = 1'b1;
                    nxt_state    = ST_SWITCH;
                end else if (parkCtl == PARK_NONE) begin
                    nxt_attached = 1'b0;
                end else begin
                    // follow a park setting changed while idle
                    nxt_owner    = parkTarget;
                    nxt_attached = 1'b1;
                end
            end
            ST_SWITCH: begin
                nxt_state    = ST_BUSY;
            end
            ST_BUSY: begin
                if (boundary) begin
                    nxt_last = owner_ff;
                    if (!anyReq) begin
                        nxt_state = ST_IDLE;
                        if (parkCtl == PARK_NONE) begin
                            nxt_attached = 1'b0;
                        end else begin
                            nxt_owner = (parkCtl == PARK_LAST) ? owner_ff : parkTarget;
                        end
                    end else if (winner != owner_ff) begin
                        nxt_owner = winner;
                    end
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_ff    <= ST_IDLE;
            owner_ff    <= '0;
            last_ff     <= '0;
            attached_ff <= 1'b1;
        end else begin
            state_ff    <= nxt_state;
            owner_ff    <= nxt_owner;
            last_ff     <= nxt_last;
            attached_ff <= nxt_attached;
        end
    end

    // outputs: grant and stalls for every requester but the active owner
    assign grantId    = owner_ff;
    assign grantValid = attached_ff;
    always_comb begin
        for (int i = 0; i < NM; i++) begin
            stallMaster[i] = reqVec[i] && !(ownerActive && owner_ff == MID_W'(i));
        end
    end

    // register file next values
    always_comb begin
        nxt_prio  = prio_ff;
        nxt_ctrl  = ctrl_ff;
        nxt_mgen  = mgen_ff;
        nxt_rdata = 32'h0000_0000;
        if (regReq.wr) begin
            case (regReq.addr)
                SLAVE_PRIORITY_OFS: nxt_prio = regReq.wdata;
                SLAVE_CONTROL_OFS:  nxt_ctrl = regReq.wdata & 32'h0000_0133;
                MASTER_GENERAL_OFS: nxt_mgen = regReq.wdata;
                default:            nxt_prio = prio_ff;
            endcase
        end
        if (regReq.rd) begin
            case (regReq.addr)
                SLAVE_PRIORITY_OFS: nxt_rdata = prio_ff;
                SLAVE_CONTROL_OFS:  nxt_rdata = ctrl_ff;
                MASTER_GENERAL_OFS: nxt_rdata = mgen_ff;
                STATUS_OFS:         nxt_rdata = {24'h000000, state_ff, attached_ff,
                                                 last_ff, owner_ff};
                default:            nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prio_ff  <= SLAVE_PRIORITY_RST;
            ctrl_ff  <= SLAVE_CONTROL_RST;
            mgen_ff  <= MASTER_GENERAL_RST;
            rdata_ff <= 32'h0000_0000;
        end else begin
            prio_ff  <= nxt_prio;
            ctrl_ff  <= nxt_ctrl;
            mgen_ff  <= nxt_mgen;
            rdata_ff <= nxt_rdata;
        end
    end
    assign regRdata = rdata_ff;

    // assertions
    a_grant_on_boundary: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_BUSY && !boundary) |=> $stable(owner_ff))
        else $error("grant changed outside a transfer boundary");
    a_switch_one_cycle: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_SWITCH) |=> (state_ff == ST_BUSY && attached_ff))
        else $error("switch took more than one cycle");
    a_parked_fast_start: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_IDLE && ownerActive) |=> state_ff == ST_BUSY)
        else $error("parked master did not start at once");
    a_parked_no_stall: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_IDLE && ownerActive) |-> !stallMaster[owner_ff])
        else $error("parked master stalled");
    a_fixed_winner: assert property (@(posedge mclk) disable iff (!rst_n)
        (!roundRobin && anyReq) |-> reqVec[winner])
        else $error("fixed priority picked an idle master");
    a_one_served: assert property (@(posedge mclk) disable iff (!rst_n)
        $onehot0(reqVec & ~stallMaster))
        else $error("more than one master served");
    a_fixed_burst_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_BUSY && ownerReq && mReq[owner_ff].hburst != HBURST_INCR)
        |=> $stable(owner_ff))
        else $error("grant moved inside a fixed burst");
    a_idle_repark: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_IDLE && !anyReq && parkCtl == PARK_FIXED)
        |=> (owner_ff == $past(parkSel) && attached_ff))
        else $error("idle port not parked on the park field");
    a_idle_unpark: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_IDLE && !anyReq && parkCtl == PARK_NONE) |=> !attached_ff)
        else $error("idle port attached with no parking");
    a_rdata_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        !regReq.rd |=> regRdata == 32'h0)
        else $error("read data outside a read answer");
    a_no_park_detach: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_BUSY && boundary && !anyReq && parkCtl == PARK_NONE)
        |=> !attached_ff)
        else $error("port stayed attached with no parking");
    a_fixed_park_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_BUSY && boundary && !anyReq && parkCtl == PARK_FIXED)
        |=> owner_ff == $past(parkSel))
        else $error("fixed park on wrong master");
    a_last_park: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_BUSY && boundary && !anyReq && parkCtl == PARK_LAST)
        |=> owner_ff == $past(owner_ff))
        else $error("park on last moved the port");
    a_lone_request: assert property (@(posedge mclk) disable iff (!rst_n)
        (state_ff == ST_IDLE && !attached_ff && $onehot(reqVec))
        |=> ##1 owner_ff == $past(winner, 2))
        else $error("lone request not granted");
    a_reset_park: assert property (@(posedge mclk)
        !rst_n |=> (owner_ff == '0 && attached_ff && ctrl_ff == 32'h0))
        else $error("reset parking wrong");
    a_rr_winner: assert property (@(posedge mclk) disable iff (!rst_n)
        (roundRobin && anyReq) |-> reqVec[winner])
        else $error("round robin picked an idle master");

    c_switch: cover property (@(posedge mclk) disable iff (!rst_n) state_ff == ST_SWITCH);
    c_handover: cover property (@(posedge mclk) disable iff (!rst_n)
        state_ff == ST_BUSY ##1 (state_ff == ST_BUSY && $changed(owner_ff)));
    c_undef_arb: cover property (@(posedge mclk) disable iff (!rst_n) undefArb);
    c_park_none: cover property (@(posedge mclk) disable iff (!rst_n)
        state_ff == ST_IDLE && !attached_ff);

endmodule : crossbar_slave_port_arbiter

//--- master_model.sv
// behavioural bus masters issuing singles, fixed bursts and undefined bursts
`timescale 1ns/1ps
module master_model #(
    parameter int NM = 4
) (
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    input  wire logic [NM-1:0]           go,
    input  wire logic [4:0]              beats [NM],
    input  wire logic [NM-1:0]           stallMaster,
    input  wire logic                    hreadySlv,
    output xbar_arb_pkg::master_req_type mReq [NM],
    output logic [NM-1:0]                beatDone
);
    import xbar_arb_pkg::*;
    logic [4:0] left_ff [NM];
    logic [4:0] total_ff [NM];
    // a beat retires only when the port serves it and the slave is ready
    always_ff @(posedge mclk) begin
        for (int i = 0; i < NM; i++) begin
            if (!rst_n) begin
                left_ff[i]  <= 5'h0;
                total_ff[i] <= 5'h0;
            end else if (go[i]) begin
                left_ff[i]  <= beats[i];
                total_ff[i] <= beats[i];
            end else if (beatDone[i]) begin
                left_ff[i] <= left_ff[i] - 5'h1;
            end
        end
    end
    // request and burst kind stand still until the beat is taken
    always_comb begin
        for (int i = 0; i < NM; i++) begin
            beatDone[i] = (left_ff[i] != 5'h0) && !stallMaster[i] && hreadySlv;
            mReq[i].htrans = (left_ff[i] == 5'h0) ? HTRANS_IDLE :
                             (left_ff[i] == total_ff[i]) ? HTRANS_NSEQ : HTRANS_SEQ;
            mReq[i].hburst = (total_ff[i] == 5'h4) ? 3'h3 :
                             (total_ff[i] == 5'h1) ? 3'h0 : HBURST_INCR;
        end
    end
endmodule : master_model

//--- crossbar_slave_port_arbiter_bench.sv
// self-checking bench for the slave port arbiter driven by bus master models
`timescale 1ns/1ps
module crossbar_slave_port_arbiter_bench;
    import xbar_arb_pkg::*;
    localparam int NM = NUM_MASTERS;
    localparam int P_CTL [8] = '{0, 0, 2, 2, 16, 16, 32, 32};
    localparam int P_M [8]   = '{0, 1, 0, 2, 1, 1, 1, 1};
    localparam int P_LAT [8] = '{0, 1, 1, 0, 1, 0, 1, 1};
    localparam int U_EXP [5] = '{20, 1, 4, 8, 16};
    logic             mclk;
    logic             rst_n;
    master_req_type   mReq [NM];
    logic             hreadySlv;
    reg_req_type      regReq;
    logic [31:0]      regRdata;
    logic [MID_W-1:0] grantId;
    logic             grantValid;
    logic [NM-1:0]    stallMaster;
    logic [NM-1:0]    go;
    logic [4:0]       beats [NM];
    logic [NM-1:0]    beatDone;
    logic             randRdy;
    logic             rdPend;
    logic             anyReq;
    int               seed = 1354;
    int               failures = 0;
    int               n_compared = 0;
    int               beats3 = 0;
    int               snap = 0;
    logic [31:0]      expQ [$];
    int               ordQ [$];

    crossbar_slave_port_arbiter #(.NM(NM)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .mReq(mReq), .hreadySlv(hreadySlv),
        .regReq(regReq), .regRdata(regRdata), .grantId(grantId),
        .grantValid(grantValid), .stallMaster(stallMaster));
    master_model #(.NM(NM)) u_masters (
        .mclk(mclk), .rst_n(rst_n), .go(go), .beats(beats), .stallMaster(stallMaster),
        .hreadySlv(hreadySlv), .mReq(mReq), .beatDone(beatDone));

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // slave side: random wait states when enabled
    always @(posedge mclk) begin
        hreadySlv <= randRdy ? ($random(seed) % 4 != 0) : 1'b1;
    end
    always_comb begin
        anyReq = 1'b0;
        for (int i = 0; i < NM; i++) anyReq = anyReq | mReq[i].htrans[1];
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // watcher: pairs read data and served transfers with the oldest notes
    always @(posedge mclk) begin
        rdPend <= regReq.rd;
        if (rdPend) check(regRdata, expQ.pop_front(), "read data");
        for (int i = 0; i < NM; i++) begin
            if (beatDone[i] && mReq[i].htrans == HTRANS_NSEQ) begin
                check(32'(i), 32'(ordQ.pop_front()), "serve order");
                if (i == 0) snap = beats3;
            end
            for (int j = 0; j < NM; j++) begin
                if (beatDone[i] && j != i && mReq[j].htrans == HTRANS_SEQ && mReq[j].hburst == 3'h3)
                    check(32'(i), 32'(j), "fixed burst broken");
            end
            if (beatDone[i] && i == 3) beats3++;
        end
    end

    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        regReq <= '0;
        @(posedge mclk);
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        expQ.push_back(e);
        regReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        regReq <= '0;
        @(posedge mclk);
    endtask : reg_rd

    // start the masters in the mask together, each with n beats
    task automatic launch(input logic [NM-1:0] mask, input logic [4:0] n);
        for (int i = 0; i < NM; i++) if (mask[i]) beats[i] <= n;
        go <= mask;
        @(posedge mclk);
        go <= '0;
        @(posedge mclk);
    endtask : launch

    // bounded wait until every note is paired and the masters are quiet
    task automatic settle();
        int t;
        t = 0;
        while ((ordQ.size() != 0 || anyReq) && t < 400) begin
            @(posedge mclk);
            t++;
        end
        check(32'(t < 400), 32'h1, "settle");
        repeat (4) @(posedge mclk);
    endtask : settle

    // one single transfer, counting crossbar stall cycles before it is served
    task automatic single(input int m, input int lat);
        int n;
        n = 0;
        ordQ.push_back(m);
        beats[m] <= 5'h1;
        go[m] <= 1'b1;
        @(posedge mclk);
        go[m] <= 1'b0;
        while (n < 20) begin
            @(negedge mclk);
            if (beatDone[m]) break;
            n++;
            @(posedge mclk);
        end
        check(32'(n), 32'(lat), "stall cycles");
        settle();
    endtask : single

    task automatic finish_test();
        $display("checks made %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test();
    end

    initial begin
        rst_n = 1'b0;
        regReq = '0;
        go = '0;
        randRdy = 1'b0;
        for (int i = 0; i < NM; i++) beats[i] = 5'h1;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        check(32'(grantId), 32'h0, "reset owner");
        check(32'(grantValid), 32'h1, "reset attach");
        @(posedge mclk);
        reg_rd(SLAVE_PRIORITY_OFS, SLAVE_PRIORITY_RST);
        reg_rd(SLAVE_CONTROL_OFS, SLAVE_CONTROL_RST);
        reg_rd(MASTER_GENERAL_OFS, MASTER_GENERAL_RST);
        reg_wr(4'hf, 32'hffff_ffff);
        reg_rd(4'hf, 32'h0);
        // parking: fixed on 0, fixed on 2, last master, none
        for (int k = 0; k < 8; k++) begin
            reg_wr(SLAVE_CONTROL_OFS, 32'(P_CTL[k]));
            repeat (3) @(posedge mclk);
            single(P_M[k], P_LAT[k]);
        end
        // fixed priority with a fixed burst under way and random wait states
        reg_wr(SLAVE_CONTROL_OFS, 32'h0);
        randRdy <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            reg_wr(SLAVE_PRIORITY_OFS, k ? 32'h0000_0123 : SLAVE_PRIORITY_RST);
            ordQ = '{1, k ? 3 : 0, k ? 0 : 3};
            launch(4'h2, 5'h4);
            launch(4'h9, 5'h1);
            settle();
        end
        // round robin ranks after the last user
        reg_wr(SLAVE_CONTROL_OFS, 32'h100);
        ordQ = '{2};
        launch(4'h4, 5'h1);
        settle();
        ordQ = '{3, 0, 1};
        launch(4'hb, 5'h1);
        settle();
        ordQ = '{2, 3, 0};
        launch(4'hd, 5'h1);
        settle();
        // undefined burst on master 3 run whole with never, else interrupted by master 0
        reg_wr(SLAVE_CONTROL_OFS, 32'h0);
        reg_wr(SLAVE_PRIORITY_OFS, SLAVE_PRIORITY_RST);
        randRdy <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            reg_wr(MASTER_GENERAL_OFS, 32'(k) << 9);
            ordQ = '{3, 0};
            beats3 = 0;
            launch(4'h8, 5'h14);
            launch(4'h1, 5'h1);
            settle();
            check(k == 1 ? 32'(snap < 4) : 32'(snap), 32'(U_EXP[k]), "takeover beat");
        end
        finish_test();
    end
endmodule : crossbar_slave_port_arbiter_bench
